// [logic/qadw_pkg.sv]
// constants and carrier types for the quad address/data write client port
package qadw_pkg;

   // ***********************************************************************
   // command framing
   // ***********************************************************************
   localparam logic [7:0] QADW_CMD_QUAD_WRITE = 8'he2;
   localparam int QADW_ADDR_W = 16;
   localparam int QADW_DATA_W = 32;
   localparam int QADW_LANES = 4;
   localparam int QADW_CNT_W = 3;
   // last count value of each phase: 8 command bits, 4 address nibbles, 8 data nibbles
   localparam logic [2:0] QADW_CMD_LAST = 3'h7;
   localparam logic [2:0] QADW_ADDR_LAST = 3'h3;
   localparam logic [2:0] QADW_DATA_LAST = 3'h7;
   localparam logic [2:0] QADW_CNT_ZERO = 3'h0;
   localparam logic [2:0] QADW_CNT_ONE = 3'h1;
   // one register is one 32-bit word, so the byte address steps by four
   localparam logic [15:0] QADW_ADDR_STEP = 16'h0004;
   localparam logic [15:0] QADW_ADDR_ZERO = 16'h0000;
   localparam logic [31:0] QADW_DATA_ZERO = 32'h0000_0000;
   localparam logic [3:0] QADW_LANES_ZERO = 4'h0;

   // ***********************************************************************
   // timing limits of the serial clock, and the system clock rate
   // ***********************************************************************
   localparam int QADW_SCK_MAX_MHZ = 80;
   localparam int QADW_READ_SCK_MAX_MHZ = 30;
   localparam int QADW_SYS_MHZ = 100;

   // ***********************************************************************
   // types
   // ***********************************************************************
   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] data;
   } qadw_wr_t;

   typedef enum logic [1:0] {
      QADW_ST_CMD,
      QADW_ST_ADDR,
      QADW_ST_DATA,
      QADW_ST_IGNORE
   } qadw_state_t;

endpackage

// [logic/qadw_cdc.sv]
// toggle handshake that carries one completed write from the serial clock to the system clock
`timescale 1ns/100ps
module qadw_cdc
   import qadw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic req_tgl,
   input wire qadw_wr_t hold,
   input wire logic drop,
   output logic valid,
   output qadw_wr_t word
);

   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic seen;
   qadw_wr_t word_q;
   logic valid_q;

   // ***********************************************************************
   // toggle synchroniser
   // ***********************************************************************
   // hold is left untouched for eight serial clocks after the toggle, far longer
   // than this path needs, so it is sampled without its own synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= req_tgl;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign seen = sync2_q ^ sync3_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_q <= '0;
         valid_q <= 1'b0;
      end else begin
         valid_q <= seen & ~drop;
         // a dropped word must not move the outputs either, or they change with no strobe
         if (seen && !drop) begin
            word_q <= hold;
         end
      end
   end

   assign valid = valid_q;
   assign word = word_q;

endmodule // qadw_cdc

// [logic/qadw_client.sv]
// serial client port decoding of the quad address/data write command
`timescale 1ns/100ps
module qadw_client
   import qadw_pkg::*;
#(
   parameter int ADDR_W = QADW_ADDR_W,
   parameter int DATA_W = QADW_DATA_W
)
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic SPI_SCK,
   input wire logic CHIP_SELECT_N,
   input wire logic [3:0] SERIAL_IO_LANES_I,
   output logic [3:0] SERIAL_IO_LANES_O,
   output logic [3:0] SERIAL_IO_LANES_OE,
   input wire logic QUAD_ONLY_SERIAL_PROTOCOL,
   output logic REG_WR_VALID,
   output logic [15:0] REG_WR_ADDR,
   output logic [31:0] REG_WR_DATA
);

   // ***********************************************************************
   // serial clock domain: frame decoding
   // ***********************************************************************
   // the frame logic is cleared by chip select itself, since the serial clock
   // stops between frames and no edge can be counted on after the last one
   logic frame_rst_n;
   qadw_state_t state_q;
   qadw_state_t state_d;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;
   logic [7:0] cmd_q;
   logic [7:0] cmd_d;
   logic [15:0] addr_q;
   logic [15:0] addr_d;
   logic [31:0] word_q;
   logic [31:0] word_d;
   logic [7:0] cmd_full;
   logic in_cmd;
   logic in_addr;
   logic in_data;
   logic cmd_match;
   logic [DATA_W/QADW_LANES-1:0] nib_hit;
   logic cmd_done;
   logic addr_done;
   logic word_done;
   logic [15:0] addr_shift;
   logic [15:0] addr_next;

   // chip select is an asynchronous clear from a pin: it must stay low until the
   // last sampling edge of a frame has passed, or that edge is lost
   assign frame_rst_n = RST_N & ~CHIP_SELECT_N;

   // ***********************************************************************
   // serial clock domain: decode wires
   // ***********************************************************************
   assign in_cmd = (state_q == QADW_ST_CMD);
   assign in_addr = (state_q == QADW_ST_ADDR);
   assign in_data = (state_q == QADW_ST_DATA);
   // command bits arrive msb first on lane 0 only
   assign cmd_full = {cmd_q[6:0], SERIAL_IO_LANES_I[0]};
   assign cmd_match = (cmd_full == QADW_CMD_QUAD_WRITE);
   assign cmd_done = in_cmd && (cnt_q == QADW_CMD_LAST);
   assign addr_done = in_addr && (cnt_q == QADW_ADDR_LAST);
   assign word_done = in_data && (cnt_q == QADW_DATA_LAST);
   assign addr_shift = {addr_q[11:0], SERIAL_IO_LANES_I};
   // a plain adder, so a run of words wraps at the top of the 16-bit space
   assign addr_next = addr_q + QADW_ADDR_STEP;

   // ***********************************************************************
   // serial clock domain: data nibble placement
   // ***********************************************************************
   // nibble k of a word fills slot k^1, so each byte arrives high half first
   for (genvar g = 0; g < DATA_W / QADW_LANES; g++) begin : g_nib
      localparam int POS = QADW_LANES * (g ^ 1);
      assign nib_hit[g] = in_data && (cnt_q == QADW_CNT_W'(g));
      assign word_d[POS +: QADW_LANES] = nib_hit[g] ? SERIAL_IO_LANES_I
         : word_q[POS +: QADW_LANES];
   end

   // ***********************************************************************
   // serial clock domain: frame sequencing
   // ***********************************************************************
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + QADW_CNT_ONE;
      cmd_d = cmd_q;
      addr_d = addr_q;
      unique case (state_q)
         QADW_ST_CMD: begin
            cmd_d = cmd_full;
            if (cmd_done) begin
               cnt_d = QADW_CNT_ZERO;
               if (cmd_match) begin
                  state_d = QADW_ST_ADDR;
               end else begin
                  state_d = QADW_ST_IGNORE;
               end
            end
         end
         QADW_ST_ADDR: begin
            addr_d = addr_shift;
            if (addr_done) begin
               cnt_d = QADW_CNT_ZERO;
               state_d = QADW_ST_DATA;
            end
         end
         QADW_ST_DATA: begin
            if (word_done) begin
               cnt_d = QADW_CNT_ZERO;
               addr_d = addr_next;
            end
         end
         QADW_ST_IGNORE: begin
            // a foreign command parks the decoder until chip select rises
            cnt_d = cnt_q;
         end
      endcase
   end

   // partial words die here when chip select rises
   always_ff @(posedge SPI_SCK or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         state_q <= QADW_ST_CMD;
         cnt_q <= QADW_CNT_ZERO;
         cmd_q <= '0;
         addr_q <= QADW_ADDR_ZERO;
         word_q <= QADW_DATA_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cmd_q <= cmd_d;
         addr_q <= addr_d;
         word_q <= word_d;
      end
   end

   // ***********************************************************************
   // serial clock domain: completed word hand-off
   // ***********************************************************************
   // these survive chip select so a word finished on the last edge still crosses
   qadw_wr_t hold_q;
   qadw_wr_t hold_d;
   logic tgl_q;

   always_comb begin
      hold_d.addr = addr_q;
      hold_d.data = word_d;
   end

   always_ff @(posedge SPI_SCK or negedge RST_N) begin
      if (!RST_N) begin
         hold_q <= '0;
         tgl_q <= 1'b0;
      end else if (word_done) begin
         hold_q <= hold_d;
         tgl_q <= ~tgl_q;
      end
   end

   // ***********************************************************************
   // system clock domain: protocol mode and write strobe
   // ***********************************************************************
   logic mode1_q;
   logic mode2_q;
   logic quad_only;
   logic wr_valid;
   qadw_wr_t wr_word;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mode1_q <= 1'b0;
         mode2_q <= 1'b0;
      end else begin
         mode1_q <= QUAD_ONLY_SERIAL_PROTOCOL;
         mode2_q <= mode1_q;
      end
   end

   // in quad-only protocol the command is never executed; gating at the strobe
   // keeps a mode change in mid-frame from tearing a half-decoded frame
   assign quad_only = mode2_q;

   qadw_cdc u_cdc (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .req_tgl(tgl_q),
      .hold(hold_q),
      .drop(quad_only),
      .valid(wr_valid),
      .word(wr_word)
   );

   // ***********************************************************************
   // outputs
   // ***********************************************************************
   // this command never drives the lanes; read data paths live elsewhere
   assign SERIAL_IO_LANES_O = QADW_LANES_ZERO;
   assign SERIAL_IO_LANES_OE = QADW_LANES_ZERO;
   assign REG_WR_VALID = wr_valid;
   assign REG_WR_ADDR = wr_word.addr;
   assign REG_WR_DATA = wr_word.data;

endmodule // qadw_client

// [verif/qadw_client_props.sv]
// assertions on the ports of the quad write client
`timescale 1ns/100ps
module qadw_client_props
   import qadw_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CHIP_SELECT_N,
   input wire logic [3:0] SERIAL_IO_LANES_O,
   input wire logic [3:0] SERIAL_IO_LANES_OE,
   input wire logic QUAD_ONLY_SERIAL_PROTOCOL,
   input wire logic REG_WR_VALID,
   input wire logic [15:0] REG_WR_ADDR,
   input wire logic [31:0] REG_WR_DATA
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_N);
   AST_NO_DRIVE: assert property (SERIAL_IO_LANES_OE == 4'h0)
      else $error("lane enable raised");
   AST_OUT_LOW: assert property (SERIAL_IO_LANES_O == 4'h0)
      else $error("lane output not low");
   // a word needs eight serial edges, so strobes can never crowd together
   AST_WORD_GAP: assert property (REG_WR_VALID |=> !REG_WR_VALID [*8])
      else $error("write strobes too close");
   AST_ADDR_HOLD: assert property ($changed(REG_WR_ADDR) |-> REG_WR_VALID)
      else $error("address moved without strobe");
   AST_DATA_HOLD: assert property ($changed(REG_WR_DATA) |-> REG_WR_VALID)
      else $error("data moved without strobe");
   AST_QUAD_BLOCK: assert property (QUAD_ONLY_SERIAL_PROTOCOL [*4] |=> !REG_WR_VALID)
      else $error("write in quad-only protocol");
   AST_IDLE_QUIET: assert property (CHIP_SELECT_N [*8] |=> !REG_WR_VALID)
      else $error("write while deselected");
   AST_RESET_QUIET: assert property ($rose(RST_N) |-> !REG_WR_VALID ##1 !REG_WR_VALID)
      else $error("write right after reset");
   cover property (REG_WR_VALID);
   cover property (REG_WR_VALID ##[9:40] REG_WR_VALID);
   cover property (QUAD_ONLY_SERIAL_PROTOCOL && $fell(CHIP_SELECT_N));
endmodule // qadw_client_props

bind qadw_client qadw_client_props u_qadw_client_props (.CLK_SYS, .RST_N, .CHIP_SELECT_N,
   .SERIAL_IO_LANES_O, .SERIAL_IO_LANES_OE, .QUAD_ONLY_SERIAL_PROTOCOL,
   .REG_WR_VALID, .REG_WR_ADDR, .REG_WR_DATA);

// [verif/qadw_host_model.sv]
// behavioural host controller driving the serial client port
`timescale 1ns/100ps
module qadw_host_model
   import qadw_pkg::*;
(
   output logic sck,
   output logic cs_n,
   output logic [3:0] lanes
);
   // 32 ns period keeps below the write clock limit; this host never reads
   localparam time HALF = 16;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      lanes = 4'h5;
   end
   task automatic edge_out(input logic [3:0] v);
      lanes = v;
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
   endtask
   // nibbles past the eighth belong to the following register
   task automatic frame(input logic [7:0] cmd, input logic [15:0] adr,
      input logic [63:0] dat, input int nib);
      int i;
      #3 cs_n = 1'b0;
      #HALF;
      for (i = 7; i >= 0; i--) edge_out({3'h0, cmd[i]});
      for (i = 3; i >= 0; i--) edge_out(adr[4*i +: 4]);
      for (i = 0; i < nib; i++) edge_out(dat[8*(i/2) + 4*(1 - i%2) +: 4]);
      #5 cs_n = 1'b1;
      // released lanes must not keep showing the last nibble
      lanes = ~lanes;
      #60;
   endtask
endmodule // qadw_host_model

// [verif/tb.sv]
// self-checking bench for the quad write client port
`timescale 1ns/100ps
module tb;
   import qadw_pkg::*;
   logic clk_sys, rst_n, quad_only, sck, cs_n, wr_valid;
   logic [3:0] lanes, lanes_o, lanes_oe;
   logic [15:0] wr_addr;
   logic [31:0] wr_data;
   int errors, checked;
   qadw_wr_t got[$];
   qadw_client u_qadw_client (.CLK_SYS(clk_sys), .RST_N(rst_n), .SPI_SCK(sck),
      .CHIP_SELECT_N(cs_n), .SERIAL_IO_LANES_I(lanes), .SERIAL_IO_LANES_O(lanes_o),
      .SERIAL_IO_LANES_OE(lanes_oe), .QUAD_ONLY_SERIAL_PROTOCOL(quad_only),
      .REG_WR_VALID(wr_valid), .REG_WR_ADDR(wr_addr), .REG_WR_DATA(wr_data));
   qadw_host_model u_qadw_host_model (.sck(sck), .cs_n(cs_n), .lanes(lanes));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) if (wr_valid === 1'b1) got.push_back('{wr_addr, wr_data});
   task automatic chk(input logic [47:0] exp, input logic [47:0] act);
      checked++;
      if (exp !== act) begin
         errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask
   // six edges cover the strobe latency of the hand-over to the system clock
   task automatic run(input logic [7:0] c, input logic [15:0] a, input logic [63:0] d,
      input int n);
      got.delete();
      @(posedge clk_sys);
      u_qadw_host_model.frame(c, a, d, n);
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic t_quad();
      quad_only <= 1'b1;
      repeat (4) @(posedge clk_sys);
      run(QADW_CMD_QUAD_WRITE, 16'h0040, 64'h1111_2222, 8);
      chk(48'h0, 48'(got.size()));
      quad_only <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic t_single();
      run(QADW_CMD_QUAD_WRITE, 16'h1234, 64'ha5c3_17e9, 8);
      chk(48'h1, 48'(got.size()));
      chk({16'h1234, 32'ha5c3_17e9}, got[0]);
   endtask
   task automatic t_multi();
      run(QADW_CMD_QUAD_WRITE, 16'hfffc, 64'h0f1e_2d3c_8796_a5b4, 16);
      chk(48'h2, 48'(got.size()));
      chk({16'hfffc, 32'h8796_a5b4}, got[0]);
      chk({16'h0000, 32'h0f1e_2d3c}, got[1]);
   endtask
   task automatic t_partial();
      run(QADW_CMD_QUAD_WRITE, 16'h0100, 64'h5555_6666_7777_8888, 13);
      chk(48'h1, 48'(got.size()));
      chk({16'h0100, 32'h7777_8888}, got[0]);
      run(QADW_CMD_QUAD_WRITE, 16'h0200, 64'h9999_aaaa, 7);
      chk(48'h0, 48'(got.size()));
      chk({16'h0100, 32'h7777_8888}, {wr_addr, wr_data});
   endtask
   task automatic t_badcmd();
      run(8'he3, 16'h0300, 64'hbbbb_cccc, 8);
      chk(48'h0, 48'(got.size()));
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      quad_only = 1'b0;
      errors = 0;
      checked = 0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_quad();
      t_single();
      t_multi();
      t_partial();
      t_badcmd();
      tally_and_finish();
   end
   initial begin
      #30000;
      errors++;
      tally_and_finish();
   end
endmodule // tb
